// ===== common/ipv_pkg.sv
// Purpose: Shared constants for the pending, vector table and priority block
// Assumes: 32-bit register port, word offsets chosen locally
// Notes: Offsets are byte addresses on the plain register port
package ipv_pkg;
  localparam int NUM_BANKS = 8;
  localparam logic [7:0] OFF_SET_PEND0 = 8'h00;
  localparam logic [7:0] OFF_VTOR = 8'h20;
  localparam logic [7:0] OFF_SHPR1 = 8'h24;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h2C;
  localparam logic [7:0] OFF_ACK_PEND0 = 8'h40;
  localparam logic [31:0] SET_PEND_RESET = 32'h0000_0000;
  localparam logic [31:0] VTOR_RESET = 32'h0000_0000;
  localparam logic [31:0] SHPR1_RESET = 32'h0000_0000;
  localparam logic [31:0] VTOR_KEEP_MASK = 32'h3FFF_FF80;
  localparam logic [31:0] SHPR1_KEEP_MASK = 32'h00FF_FFFF;
  localparam int VTOR_REGION_BIT = 29;
  localparam int USAGE_PRI_LSB = 16;
  localparam int BUS_PRI_LSB = 8;
  localparam int MEM_PRI_LSB = 0;
  localparam int PRI_WIDTH = 8;
  localparam int EVT_PEND_SET = 0;
  localparam int EVT_VTOR_WRITE = 1;
  localparam int EVT_BAD_ADDR = 2;
  localparam int NUM_EVENTS = 3;
endpackage

// ===== rtl/ipv_pend_mem.sv
// Purpose: Bank memory of pending bits with registered read data
// Assumes: One set port, one ack port and one read port, same clock
// Notes: Set bits only accumulate; clears come through ack_bits
`timescale 1ns/1ps
module ipv_pend_mem #(
  parameter int BANKS = 8,
  parameter int AW = 3
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [AW-1:0] set_bank_in,
  input wire logic set_en_in,
  input wire logic [31:0] set_bits_in,
  input wire logic [AW-1:0] ack_bank_in,
  input wire logic ack_en_in,
  input wire logic [31:0] ack_bits_in,
  input wire logic [AW-1:0] rd_bank_in,
  output logic [31:0] rd_data_out,
  output logic [BANKS-1:0] bank_any_out
);
  logic [31:0] mem_reg [BANKS];

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < BANKS; i++) begin
      if (!reset_n_in) begin
        mem_reg[i] <= ipv_pkg::SET_PEND_RESET;
      end else begin
        // Set wins over clear for the same bit in the same cycle
        mem_reg[i] <= (mem_reg[i]
                       & ~((ack_en_in && ack_bank_in == AW'(i)) ? ack_bits_in : 32'h0000_0000))
                      | ((set_en_in && set_bank_in == AW'(i)) ? set_bits_in : 32'h0000_0000);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rd_data_out <= 32'h0000_0000;
    end else begin
      rd_data_out <= mem_reg[rd_bank_in];
    end
  end

  always_comb begin
    for (int i = 0; i < BANKS; i++) begin
      bank_any_out[i] = |mem_reg[i];
    end
  end
endmodule

// ===== rtl/ipv_core.sv
// Purpose: Set-pending banks, vector table offset and fault priorities
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: Core acknowledges taken interrupts through ack port
`timescale 1ns/1ps
module ipv_core #(
  parameter int BANKS = ipv_pkg::NUM_BANKS,
  parameter int EXC_W = 9
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [BANKS*32-1:0] irq_enable_in,
  input wire logic ack_en_in,
  input wire logic [$clog2(BANKS)-1:0] ack_bank_in,
  input wire logic [31:0] ack_bits_in,
  input wire logic [EXC_W-1:0] exc_num_in,
  output logic [31:0] vector_addr_out,
  output logic table_region_select_out,
  output logic [7:0] usage_error_priority_out,
  output logic [7:0] bus_error_priority_out,
  output logic [7:0] mem_protect_priority_out,
  output logic pending_any_out,
  output logic pending_enabled_out,
  output logic irq_out
);
  localparam int AW = $clog2(BANKS);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic in_pend_window(input logic [7:0] a, input logic [7:0] base);
    in_pend_window = (a >= base) && (a < base + 8'(BANKS * 4)) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [AW-1:0] bank_of(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    bank_of = d[AW+1:2];
  endfunction

  logic wr_pend;
  logic wr_vtor;
  logic wr_shpr;
  logic wr_stat;
  logic wr_mask;
  logic rd_pend;
  logic known;
  logic [AW-1:0] acc_bank;

  always_comb begin
    rd_pend = in_pend_window(addr_in, ipv_pkg::OFF_SET_PEND0);
    acc_bank = bank_of(addr_in, ipv_pkg::OFF_SET_PEND0);
    known = rd_pend || addr_in == ipv_pkg::OFF_VTOR || addr_in == ipv_pkg::OFF_SHPR1
            || addr_in == ipv_pkg::OFF_IRQ_STATUS || addr_in == ipv_pkg::OFF_IRQ_MASK;
    wr_pend = wr_in && rd_pend;
    wr_vtor = wr_in && addr_in == ipv_pkg::OFF_VTOR;
    wr_shpr = wr_in && addr_in == ipv_pkg::OFF_SHPR1;
    wr_stat = wr_in && addr_in == ipv_pkg::OFF_IRQ_STATUS;
    wr_mask = wr_in && addr_in == ipv_pkg::OFF_IRQ_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending store

  logic [31:0] pend_rd;
  logic [BANKS-1:0] bank_any;
  logic [31:0] cur_pend;

  // Only zero-to-one transitions count as a new event; a repeat set is silent
  ipv_pend_mem #(
    .BANKS(BANKS),
    .AW(AW)
  ) u_mem (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .set_bank_in(acc_bank),
    .set_en_in(wr_pend),
    .set_bits_in(wdata_in),
    .ack_bank_in(ack_bank_in),
    .ack_en_in(ack_en_in),
    .ack_bits_in(ack_bits_in),
    .rd_bank_in(acc_bank),
    .rd_data_out(pend_rd),
    .bank_any_out(bank_any)
  );

  // Shadow copy lets us tell new sets from repeats and check enables
  logic [31:0] shadow_reg [BANKS];
  logic new_set;
  logic any_en;

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < BANKS; i++) begin
      if (!reset_n_in) begin
        shadow_reg[i] <= ipv_pkg::SET_PEND_RESET;
      end else begin
        shadow_reg[i] <= (shadow_reg[i]
                         & ~((ack_en_in && ack_bank_in == AW'(i)) ? ack_bits_in : 32'h0000_0000))
                         | ((wr_pend && acc_bank == AW'(i)) ? wdata_in : 32'h0000_0000);
      end
    end
  end

  always_comb begin
    cur_pend = shadow_reg[acc_bank];
    new_set = wr_pend && |(wdata_in & ~cur_pend);
    any_en = 1'b0;
    for (int i = 0; i < BANKS; i++) begin
      any_en = any_en | |(shadow_reg[i] & irq_enable_in[i*32 +: 32]);
    end
  end

  assign pending_any_out = |bank_any;
  assign pending_enabled_out = any_en;

  ////////////////////////////////////////////////////////////////////////////
  // Vector table offset

  logic [31:0] vtor_reg;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      vtor_reg <= ipv_pkg::VTOR_RESET;
    end else if (wr_vtor) begin
      vtor_reg <= wdata_in & ipv_pkg::VTOR_KEEP_MASK;
    end
  end

  assign table_region_select_out = vtor_reg[ipv_pkg::VTOR_REGION_BIT];

  // The write mask keeps the offset 128-byte aligned; exception numbers from 32 up carry into offset bits, so a full add is used
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      vector_addr_out <= 32'h0000_0000;
    end else begin
      vector_addr_out <= vtor_reg + {{(30 - EXC_W){1'b0}}, exc_num_in, 2'b00};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System handler priorities

  logic [31:0] shpr_reg;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      shpr_reg <= ipv_pkg::SHPR1_RESET;
    end else if (wr_shpr) begin
      shpr_reg <= wdata_in & ipv_pkg::SHPR1_KEEP_MASK;
    end
  end

  assign usage_error_priority_out = shpr_reg[ipv_pkg::USAGE_PRI_LSB +: ipv_pkg::PRI_WIDTH];
  assign bus_error_priority_out = shpr_reg[ipv_pkg::BUS_PRI_LSB +: ipv_pkg::PRI_WIDTH];
  assign mem_protect_priority_out = shpr_reg[ipv_pkg::MEM_PRI_LSB +: ipv_pkg::PRI_WIDTH];

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  logic [ipv_pkg::NUM_EVENTS-1:0] stat_reg;
  logic [ipv_pkg::NUM_EVENTS-1:0] mask_reg;
  logic [ipv_pkg::NUM_EVENTS-1:0] evt;

  always_comb begin
    evt = '0;
    evt[ipv_pkg::EVT_PEND_SET] = new_set;
    evt[ipv_pkg::EVT_VTOR_WRITE] = wr_vtor;
    evt[ipv_pkg::EVT_BAD_ADDR] = (wr_in || rd_in) && !known;
  end

  // A new event in the clearing cycle survives the write-one-to-clear
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~(wr_stat ? wdata_in[ipv_pkg::NUM_EVENTS-1:0] : '0)) | evt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mask_reg <= '0;
    end else if (wr_mask) begin
      mask_reg <= wdata_in[ipv_pkg::NUM_EVENTS-1:0];
    end
  end

  assign irq_out = |(stat_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] rd_addr_reg;
  logic rd_pend_reg;
  logic rd_any_reg;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rd_addr_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_any_reg <= 1'b0;
    end else begin
      rd_addr_reg <= addr_in;
      rd_pend_reg <= rd_in && rd_pend;
      rd_any_reg <= rd_in;
    end
  end

  logic [31:0] reg_rd_reg;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      reg_rd_reg <= 32'h0000_0000;
    end else if (rd_in) begin
      case (addr_in)
        ipv_pkg::OFF_VTOR: reg_rd_reg <= vtor_reg;
        ipv_pkg::OFF_SHPR1: reg_rd_reg <= shpr_reg;
        ipv_pkg::OFF_IRQ_STATUS: reg_rd_reg <= 32'(stat_reg);
        ipv_pkg::OFF_IRQ_MASK: reg_rd_reg <= 32'(mask_reg);
        default: reg_rd_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Pending reads come from the memory's own output register
  always_comb begin
    if (!rd_any_reg) begin
      rdata_out = 32'h0000_0000;
    end else if (rd_pend_reg) begin
      rdata_out = pend_rd;
    end else begin
      rdata_out = reg_rd_reg;
    end
  end
endmodule

// ===== tb/ipv_chk.sv
// Purpose: Port checks for the pending, table base and priority block
// Assumes: One clock, synchronous active-low reset
// Notes: Table base shadow follows software writes only
`timescale 1ns/1ps
module ipv_chk #(
  parameter int EXC_W = 9
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic ack_en_in,
  input wire logic [EXC_W-1:0] exc_num_in,
  input wire logic [31:0] vector_addr_out,
  input wire logic table_region_select_out,
  input wire logic [7:0] usage_error_priority_out,
  input wire logic [7:0] bus_error_priority_out,
  input wire logic [7:0] mem_protect_priority_out,
  input wire logic pending_any_out
);
  ////////////////////////////////////////
  logic [31:0] vtor_sh_reg;
  wire vt_wr = wr_in && addr_in == ipv_pkg::OFF_VTOR;
  wire pd_acc = addr_in == ipv_pkg::OFF_SET_PEND0;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      vtor_sh_reg <= '0;
    end else if (vt_wr) begin
      vtor_sh_reg <= wdata_in & ipv_pkg::VTOR_KEEP_MASK;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////
  a_rdata_quiet: assert property (!$past(rd_in) |-> rdata_out == 0)
    else $error("read data outside its slot");
  a_vtor_readback: assert property (rd_in && addr_in == ipv_pkg::OFF_VTOR
    |=> rdata_out == $past(vtor_sh_reg)) else $error("table base readback wrong");
  a_vtor_low_zero: assert property (rd_in && addr_in == ipv_pkg::OFF_VTOR
    |=> rdata_out[6:0] == 0) else $error("table base low bits not zero");
  a_region_bit: assert property (table_region_select_out == vtor_sh_reg[29])
    else $error("region select wrong");
  a_vector_addr: assert property ($past(reset_n_in) |-> vector_addr_out ==
    $past(vtor_sh_reg) + (32'($past(exc_num_in)) << 2)) else $error("vector address wrong");
  a_pri_fields: assert property (wr_in && addr_in == ipv_pkg::OFF_SHPR1 |=>
    {usage_error_priority_out, bus_error_priority_out, mem_protect_priority_out}
    == $past(wdata_in[23:0])) else $error("priority fields wrong");
  a_shpr_top_zero: assert property (rd_in && addr_in == ipv_pkg::OFF_SHPR1
    |=> rdata_out[31:24] == 0) else $error("reserved priority byte not zero");
  a_pend_readback: assert property (wr_in && pd_acc ##2 rd_in && pd_acc |=>
    (rdata_out & $past(wdata_in, 3)) == $past(wdata_in, 3)) else $error("pend bit lost");
  a_pend_hold: assert property (pending_any_out && !ack_en_in && !$past(ack_en_in)
    |=> pending_any_out) else $error("pending dropped without ack");
endmodule
bind ipv_core ipv_chk #(.EXC_W(EXC_W)) u_chk (.clk_in, .reset_n_in, .addr_in, .wdata_in,
  .wr_in, .rd_in, .rdata_out, .ack_en_in, .exc_num_in, .vector_addr_out,
  .table_region_select_out, .usage_error_priority_out, .bus_error_priority_out,
  .mem_protect_priority_out, .pending_any_out);

// ===== tb/ipv_core_model.sv
// Purpose: Core-side model that takes interrupts and asks for vectors
// Assumes: One bank acknowledged per call, one-cycle pulse
// Notes: Wait argument lets it answer promptly or slowly
`timescale 1ns/1ps
module ipv_core_model (
  input wire logic clk_in,
  output logic ack_en_out,
  output logic [2:0] ack_bank_out,
  output logic [31:0] ack_bits_out,
  output logic [8:0] exc_num_out
);
  initial begin
    ack_en_out = 1'b0;
    ack_bank_out = '0;
    ack_bits_out = '0;
    exc_num_out = '0;
  end
  task automatic take(input logic [2:0] bank, input logic [31:0] bits, input int gap);
    repeat (gap) @(posedge clk_in);
    ack_en_out <= 1'b1;
    ack_bank_out <= bank;
    ack_bits_out <= bits;
    @(posedge clk_in);
    ack_en_out <= 1'b0;
    // Stale bits would hide a design that ignores the enable
    ack_bits_out <= ~bits;
  endtask
  task automatic fetch(input logic [8:0] num);
    @(posedge clk_in);
    exc_num_out <= num;
  endtask
endmodule

// ===== tb/irq_pend_vector_priority_tb.sv
// Purpose: Register-level tests of the pending, table base and priority block
// Assumes: Plain register port, read data one cycle after the strobe
// Notes: Offsets from the shared package
`timescale 1ns/1ps
module irq_pend_vector_priority_tb;
  logic clk_in = 0, reset_n_in = 0, wr_in = 0, rd_in = 0;
  logic [7:0] addr_in = '0;
  logic [31:0] wdata_in = '0;
  logic [255:0] irq_enable_in = '0;
  logic [31:0] rdata_out, vector_addr_out, ack_bits_in;
  logic [7:0] usage_error_priority_out, bus_error_priority_out, mem_protect_priority_out;
  logic table_region_select_out, pending_any_out, pending_enabled_out, irq_out, ack_en_in;
  logic [2:0] ack_bank_in;
  logic [8:0] exc_num_in;
  int fails = 0, num_checks = 0;
  initial forever #20 clk_in = ~clk_in;
  ipv_core dut (.clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .irq_enable_in, .ack_en_in, .ack_bank_in, .ack_bits_in, .exc_num_in, .vector_addr_out,
    .table_region_select_out, .usage_error_priority_out, .bus_error_priority_out,
    .mem_protect_priority_out, .pending_any_out, .pending_enabled_out, .irq_out);
  ipv_core_model core (.clk_in, .ack_en_out(ack_en_in), .ack_bank_out(ack_bank_in),
    .ack_bits_out(ack_bits_in), .exc_num_out(exc_num_in));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    rd_in <= 1'b0;
    addr_in <= a;
    wdata_in <= d;
    // One-cycle strobe: a held strobe would write again at every edge
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic idle;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    addr_in <= a;
    idle;
    chk(rdata_out, exp);
  endtask
  task automatic test_done;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_in);
    fails++;
    test_done;
  end
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int b = 0; b < 8; b++) rd(8'(4 * b), ipv_pkg::SET_PEND_RESET);
    rd(ipv_pkg::OFF_VTOR, ipv_pkg::VTOR_RESET);
    rd(ipv_pkg::OFF_SHPR1, ipv_pkg::SHPR1_RESET);
    rd(ipv_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    wr(ipv_pkg::OFF_SET_PEND0, 32'h0000_0010);
    rd(ipv_pkg::OFF_SET_PEND0, 32'h0000_0010);
    core.take(3'd0, 32'h0000_0010, 1);
    wr(8'h0C, 32'h8000_0001);
    rd(8'h0C, 32'h8000_0001);
    chk(32'(pending_enabled_out), 32'h0000_0000);
    wr(8'h0C, 32'h0000_0000);
    wr(ipv_pkg::OFF_IRQ_STATUS, 32'h0000_0007);
    wr(8'h0C, 32'h0000_0001);
    rd(8'h0C, 32'h8000_0001);
    rd(ipv_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
    irq_enable_in[96] <= 1'b1;
    idle;
    idle;
    chk(32'(pending_enabled_out), 32'h0000_0001);
    core.take(3'd3, 32'h8000_0001, 3);
    rd(8'h0C, 32'h0000_0000);
    chk(32'(pending_any_out), 32'h0000_0000);
    wr(ipv_pkg::OFF_VTOR, 32'hFFFF_FFFF);
    rd(ipv_pkg::OFF_VTOR, 32'h3FFF_FF80);
    chk(32'(table_region_select_out), 32'h0000_0001);
    wr(ipv_pkg::OFF_VTOR, 32'h0000_0100);
    core.fetch(9'd11);
    idle;
    idle;
    chk(32'(table_region_select_out), 32'h0000_0000);
    chk(vector_addr_out, 32'h0000_012C);
    rd(ipv_pkg::OFF_IRQ_STATUS, 32'h0000_0002);
    chk(32'(irq_out), 32'h0000_0000);
    wr(ipv_pkg::OFF_SHPR1, 32'hA1B2_C3D4);
    rd(ipv_pkg::OFF_SHPR1, 32'h00B2_C3D4);
    chk({8'h00, usage_error_priority_out, bus_error_priority_out,
      mem_protect_priority_out}, 32'h00B2_C3D4);
    wr(ipv_pkg::OFF_IRQ_MASK, 32'h0000_0004);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, 32'h0000_0000);
    rd(8'h02, 32'h0000_0000);
    rd(ipv_pkg::OFF_IRQ_MASK, 32'h0000_0004);
    chk(32'(irq_out), 32'h0000_0001);
    wr(ipv_pkg::OFF_IRQ_STATUS, 32'h0000_0006);
    idle;
    idle;
    chk(32'(irq_out), 32'h0000_0000);
    test_done;
  end
endmodule
